// File: design/pin_ctrl_pkg.sv
/*
 Package for the pin-level control block: register offsets, field positions,
 reset values and timing counts.
 Assumes a 32-bit Avalon-MM slave port on a 20 MHz system clock.
*/
package pin_ctrl_pkg;
   // ==========================================================
   // bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CLOCK_OUT_CONTROL = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 4'hc;
   // the enable register sits on a fifth word; 0x10 needs five address bits, one more than ADDR_W
   localparam logic [4:0] OFF_IRQ_ENABLE = 5'h10;
   localparam logic [4:0] OFF_MISC_CONTROL = 5'h14;
   // ==========================================================
   // timer control fields
   localparam int TC_IRQ_ZERO_EDGE_BIT = 0;
   localparam int TC_IRQ_ONE_EDGE_BIT = 2;
   // clock-out control fields
   localparam int CO_TIMER_ZERO_BIT = 0;
   localparam int CO_TIMER_ONE_BIT = 1;
   localparam int CO_TIMER_TWO_BIT = 2;
   // misc control fields
   localparam int MC_RESET_IND_BIT = 0;
   localparam int MC_MCLK_EN_BIT = 1;
   localparam int MC_MCLK_DIV_LSB = 2;
   localparam int MC_CLK_SRC_LSB = 4;
   // ==========================================================
   // reset values
   localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
   localparam logic [2:0] CLOCK_OUT_RST = 3'h0;
   localparam logic [4:0] IRQ_ENABLE_RST = 5'h00;
   localparam logic [5:0] MISC_CONTROL_RST = 6'h00;
   // ==========================================================
   // number of external interrupt inputs
   localparam int N_IRQ = 5;
   // reset pin must stay high this many machine cycles (1T: one clock each)
   localparam int RESET_PIN_MIN_CYCLES = 2;
   // ==========================================================
   // master clock divide selection
   typedef enum logic [1:0] {
      div_by_one,
      div_by_two,
      div_by_four,
      div_reserved
   } mclk_div_e;
   // master clock source selection
   typedef enum logic [1:0] {
      src_internal_rc,
      src_ext_clock,
      src_ext_crystal,
      src_unused
   } clk_src_e;
endpackage

// File: design/edge_irq.sv
/*
 One external interrupt input: two-stage synchroniser, edge detector with
 selectable both-edge or falling-only mode, sticky pending flag and an
 asynchronous falling-edge wake request for power-down.
 Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/100ps
module edge_irq (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // pin and control
   input wire logic pin,
   input wire logic falling_only,
   input wire logic clear,
   input wire logic wake_arm,
   // results
   output logic pending,
   output logic wake
);
   logic sync1_q;
   logic sync2_q;
   logic last_q;
   logic fall;
   logic rise;
   logic hit;
   logic pending_q;
   logic wake_q;

   // ==========================================================
   // synchroniser and edge detect
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end

   assign fall = last_q & ~sync2_q;
   assign rise = ~last_q & sync2_q;
   assign hit = fall | (rise & ~falling_only);

   // ==========================================================
   // sticky pending, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pending_q <= 1'b0;
      end else if (hit) begin
         pending_q <= 1'b1;
      end else if (clear) begin
         pending_q <= 1'b0;
      end
   end

   // ==========================================================
   // wake latch works without the clock: a falling pin edge while armed sets it
   always_ff @(negedge pin or negedge wake_arm) begin
      if (!wake_arm) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= 1'b1;
      end
   end

   assign pending = pending_q;
   // gated by the arm so an unarmed latch never shows its power-up value
   assign wake = wake_q & wake_arm;
endmodule

// File: design/pin_ctrl.sv
/*
 Pin-level control block: five external interrupt inputs, timer clock-out
 enables, divided master clock output, reset pin filter and reset indicator.
 Assumes an Avalon-MM master on sys_clk and the selected master clock
 arriving as a plain level on one of three source pins.
*/
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module pin_ctrl
   import pin_ctrl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pin_ctrl_pkg::DATA_W-1:0] avs_writedata,
   output logic [pin_ctrl_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // external interrupt pins
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic ext_irq_two_pin,
   input wire logic ext_irq_three_pin,
   input wire logic ext_irq_four_pin,
   // power-down control and wake
   input wire logic power_down,
   output logic wake_up,
   // timer toggle sources and clock-out pins
   input wire logic timer_zero_toggle,
   input wire logic timer_one_toggle,
   input wire logic timer_two_toggle,
   output logic timer_zero_clock_out,
   output logic timer_one_clock_out,
   output logic timer_two_clock_out,
   output logic timer_zero_clock_out_en,
   output logic timer_one_clock_out_en,
   output logic timer_two_clock_out_en,
   // master clock sources and output
   input wire logic rc_osc_clk,
   input wire logic ext_clk_in,
   input wire logic xtal_osc_clk,
   output logic master_clock_out_pin,
   // reset pin and indicator
   input wire logic reset_pin,
   output logic device_reset,
   output logic reset_indicator_out,
   // interrupt
   output logic irq
);
   import pin_ctrl_pkg::*;

   logic [7:0] timer_control_q;
   logic [2:0] clock_out_control_q;
   logic [N_IRQ-1:0] irq_enable_q;
   logic [5:0] misc_control_q;
   logic [N_IRQ-1:0] pending;
   logic [N_IRQ-1:0] wake;
   logic [N_IRQ-1:0] clear_d;
   logic [N_IRQ-1:0] falling_only;
   logic [N_IRQ-1:0] pins;
   logic [N_IRQ-1:0] wake_arm;
   logic [DATA_W-1:0] readdata_d;
   logic ack_q;
   logic access;
   logic irq_q;
   logic wake_q;

   // ==========================================================
   // per-input edge detectors
   assign pins = {ext_irq_four_pin, ext_irq_three_pin, ext_irq_two_pin, ext_irq_one_pin, ext_irq_zero_pin};
   assign falling_only[0] = timer_control_q[TC_IRQ_ZERO_EDGE_BIT];
   assign falling_only[1] = timer_control_q[TC_IRQ_ONE_EDGE_BIT];
   assign falling_only[2] = 1'b1;
   assign falling_only[3] = 1'b1;
   assign falling_only[4] = 1'b1;
   // input zero has no wake path
   assign wake_arm = {{(N_IRQ-1){power_down}}, 1'b0};

   genvar gi;
   generate
      for (gi = 0; gi < N_IRQ; gi++) begin : g_irq
         edge_irq u_edge (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .pin(pins[gi]),
            .falling_only(falling_only[gi]),
            .clear(clear_d[gi]),
            .wake_arm(wake_arm[gi]),
            .pending(pending[gi]),
            .wake(wake[gi])
         );
      end
   endgenerate

   // ==========================================================
   // bus slave: one wait cycle per access
   assign access = (avs_read | avs_write) & ~ack_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~access;
      end
   end

   always_comb begin
      readdata_d = '0;
      case (avs_address)
         {1'b0, OFF_TIMER_CONTROL}: readdata_d[7:0] = timer_control_q;
         {1'b0, OFF_CLOCK_OUT_CONTROL}: readdata_d[2:0] = clock_out_control_q;
         {1'b0, OFF_IRQ_STATUS}: readdata_d[N_IRQ-1:0] = pending;
         OFF_IRQ_ENABLE: readdata_d[N_IRQ-1:0] = irq_enable_q;
         OFF_MISC_CONTROL: readdata_d[5:0] = misc_control_q;
         default: readdata_d = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         avs_readdata <= '0;
      end else if (access && avs_read) begin
         avs_readdata <= readdata_d;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         timer_control_q <= TIMER_CONTROL_RST;
         clock_out_control_q <= CLOCK_OUT_RST;
         irq_enable_q <= IRQ_ENABLE_RST;
         misc_control_q <= MISC_CONTROL_RST;
      end else if (access && avs_write) begin
         case (avs_address)
            {1'b0, OFF_TIMER_CONTROL}: timer_control_q <= avs_writedata[7:0];
            {1'b0, OFF_CLOCK_OUT_CONTROL}: clock_out_control_q <= avs_writedata[2:0];
            OFF_IRQ_ENABLE: irq_enable_q <= avs_writedata[N_IRQ-1:0];
            OFF_MISC_CONTROL: misc_control_q <= avs_writedata[5:0];
            default: ;
         endcase
      end
   end

   // write-one-to-clear pulses
   always_comb begin
      clear_d = '0;
      if (access && avs_write && avs_address == {1'b0, OFF_IRQ_CLEAR}) begin
         clear_d = avs_writedata[N_IRQ-1:0];
      end
   end

   // ==========================================================
   // interrupt and wake outputs
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(pending & irq_enable_q);
      end
   end
   assign irq = irq_q;

   // wake latches run unclocked; the or is registered only for the clocked view
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= |wake;
      end
   end
   assign wake_up = |wake | wake_q;

   // ==========================================================
   // timer clock outputs
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         timer_zero_clock_out <= 1'b0;
         timer_one_clock_out <= 1'b0;
         timer_two_clock_out <= 1'b0;
         timer_zero_clock_out_en <= 1'b0;
         timer_one_clock_out_en <= 1'b0;
         timer_two_clock_out_en <= 1'b0;
      end else begin
         timer_zero_clock_out <= timer_zero_toggle & clock_out_control_q[CO_TIMER_ZERO_BIT];
         timer_one_clock_out <= timer_one_toggle & clock_out_control_q[CO_TIMER_ONE_BIT];
         timer_two_clock_out <= timer_two_toggle & clock_out_control_q[CO_TIMER_TWO_BIT];
         timer_zero_clock_out_en <= clock_out_control_q[CO_TIMER_ZERO_BIT];
         timer_one_clock_out_en <= clock_out_control_q[CO_TIMER_ONE_BIT];
         timer_two_clock_out_en <= clock_out_control_q[CO_TIMER_TWO_BIT];
      end
   end

   // ==========================================================
   // master clock source select and divider
   logic [2:0] src_sync1_q;
   logic [2:0] src_sync2_q;
   logic src_last_q;
   logic mclk_sel;
   logic mclk_rise;
   logic [1:0] div_cnt_q;
   logic mclk_out_q;
   clk_src_e clk_src;
   mclk_div_e mclk_div;

   assign clk_src = clk_src_e'(misc_control_q[MC_CLK_SRC_LSB +: 2]);
   assign mclk_div = mclk_div_e'(misc_control_q[MC_MCLK_DIV_LSB +: 2]);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         src_sync1_q <= 3'h0;
         src_sync2_q <= 3'h0;
      end else begin
         src_sync1_q <= {xtal_osc_clk, ext_clk_in, rc_osc_clk};
         src_sync2_q <= src_sync1_q;
      end
   end

   always_comb begin
      case (clk_src)
         src_internal_rc: mclk_sel = src_sync2_q[0];
         src_ext_clock: mclk_sel = src_sync2_q[1];
         src_ext_crystal: mclk_sel = src_sync2_q[2];
         default: mclk_sel = src_sync2_q[0];
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         src_last_q <= 1'b0;
      end else begin
         src_last_q <= mclk_sel;
      end
   end
   assign mclk_rise = mclk_sel & ~src_last_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         div_cnt_q <= 2'h0;
         mclk_out_q <= 1'b0;
      end else if (!misc_control_q[MC_MCLK_EN_BIT]) begin
         div_cnt_q <= 2'h0;
         mclk_out_q <= 1'b0;
      end else begin
         case (mclk_div)
            div_by_one: mclk_out_q <= mclk_sel;
            div_by_two: begin
               if (mclk_rise) begin
                  mclk_out_q <= ~mclk_out_q;
               end
            end
            div_by_four: begin
               if (mclk_rise) begin
                  div_cnt_q <= div_cnt_q + 2'h1;
                  if (div_cnt_q[0]) begin
                     mclk_out_q <= ~mclk_out_q;
                  end
               end
            end
            default: mclk_out_q <= 1'b0;
         endcase
      end
   end
   assign master_clock_out_pin = mclk_out_q;

   // ==========================================================
   // reset pin filter
   logic rst_sync1_q;
   logic rst_sync2_q;
   logic [1:0] rst_cnt_q;
   logic device_reset_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= reset_pin;
         rst_sync2_q <= rst_sync1_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rst_cnt_q <= 2'h0;
         device_reset_q <= 1'b0;
      end else if (!rst_sync2_q) begin
         rst_cnt_q <= 2'h0;
         device_reset_q <= 1'b0;
      end else if (rst_cnt_q < 2'(RESET_PIN_MIN_CYCLES - 1)) begin
         rst_cnt_q <= rst_cnt_q + 2'h1;
      end else begin
         device_reset_q <= 1'b1;
      end
   end
   assign device_reset = device_reset_q;

   // ==========================================================
   // reset indicator
   always_ff @(posedge sys_clk) begin
      if (!reset_n || device_reset_q) begin
         reset_indicator_out <= 1'b0;
      end else begin
         reset_indicator_out <= misc_control_q[MC_RESET_IND_BIT];
      end
   end
endmodule

// File: test/pin_ctrl_chk.sv
/*
 Port checker for pin_ctrl: bus answer timing, clock-out gating,
 reset pin filter, reset indicator and wake-up.
 Assumes a single sys_clk domain with synchronous active-low reset_n.
*/
`timescale 1ns/100ps
module pin_ctrl_chk (
   // clock, reset and bus
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // pins
   input wire logic ext_irq_three_pin,
   input wire logic power_down,
   input wire logic wake_up,
   input wire logic timer_zero_clock_out,
   input wire logic timer_zero_clock_out_en,
   input wire logic timer_two_clock_out,
   input wire logic timer_two_clock_out_en,
   input wire logic reset_pin,
   input wire logic device_reset,
   input wire logic reset_indicator_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // assertions
   chk_reset_outputs: assert property (disable iff (1'b0) !reset_n |=> avs_waitrequest && !reset_indicator_out)
      else $error("outputs not at reset level");
   chk_read_answer: assert property ($rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   chk_answer_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held longer than one cycle");
   chk_zero_out_gate: assert property (timer_zero_clock_out |-> timer_zero_clock_out_en)
      else $error("timer zero clock out without enable");
   chk_two_out_gate: assert property (timer_two_clock_out |-> timer_two_clock_out_en)
      else $error("timer two clock out without enable");
   chk_short_pulse: assert property ($rose(reset_pin) ##1 !reset_pin |-> ##1 !device_reset[*5])
      else $error("one cycle reset pulse accepted");
   chk_long_pulse: assert property ($rose(reset_pin) ##1 reset_pin[*7] |-> ##[0:2] device_reset)
      else $error("long reset pulse ignored");
   chk_ind_in_reset: assert property (device_reset[*2] |-> !reset_indicator_out)
      else $error("reset indicator high during device reset");
   chk_wake_set: assert property (power_down && $past(power_down) && $fell(ext_irq_three_pin) |-> ##[0:2] wake_up)
      else $error("falling edge did not wake");
   chk_wake_clear: assert property (!power_down[*2] |-> !wake_up)
      else $error("wake held without power down");
   // ==========================================================
   // covers
   cov_wake: cover property ($rose(wake_up));
   cov_dev_reset: cover property ($rose(device_reset));
   cov_clock_out: cover property ($rose(timer_two_clock_out));
endmodule

bind pin_ctrl pin_ctrl_chk pin_ctrl_chk_inst (.sys_clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
   .ext_irq_three_pin, .power_down, .wake_up, .timer_zero_clock_out, .timer_zero_clock_out_en,
   .timer_two_clock_out, .timer_two_clock_out_en, .reset_pin, .device_reset, .reset_indicator_out);

// File: test/pin_ctrl_partner.sv
/*
 Far-side model: interrupt sources driven on command and three slow
 master clock sources at unequal rates.
 Assumes sys_clk at 20 MHz; sources stay slower than a quarter of it.
*/
`timescale 1ns/100ps
module pin_ctrl_partner (
   // clock and commands
   input wire logic sys_clk,
   input wire logic [4:0] pin_cmd,
   // towards the block
   output logic [4:0] irq_pins,
   output logic rc_osc_clk,
   output logic ext_clk_in,
   output logic xtal_osc_clk
);
   int n = 0;
   initial begin
      irq_pins = 5'h1f;
      rc_osc_clk = 0;
      ext_clk_in = 0;
      xtal_osc_clk = 0;
   end
   always @(posedge sys_clk) begin
      n <= n + 1;
      irq_pins <= pin_cmd;
      rc_osc_clk <= (n % 10) < 5;
      ext_clk_in <= (n % 14) < 7;
      xtal_osc_clk <= (n % 18) < 9;
   end
endmodule

// File: test/pin_ctrl_tb_top.sv
/*
 Top bench for pin_ctrl: bus tasks, reference model of pending flags,
 clock ratio counts and the verdict.
 Assumes the partner model and the bound checker.
*/
`timescale 1ns/100ps
module pin_ctrl_tb_top;
   import pin_ctrl_pkg::*;
   logic sys_clk = 0;
   logic reset_n = 0;
   logic [4:0] avs_address = 0;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, wake_up, device_reset, reset_indicator_out, irq, rc, ec, xc, mclk;
   logic power_down = 0;
   logic reset_pin = 0;
   logic [2:0] tgl = 0;
   logic [2:0] co, coe;
   logic [4:0] pin_cmd = 5'h1f;
   logic [4:0] pins;
   logic [4:0] offs[7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;

   pin_ctrl pin_ctrl_inst (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .ext_irq_zero_pin(pins[0]), .ext_irq_one_pin(pins[1]),
      .ext_irq_two_pin(pins[2]), .ext_irq_three_pin(pins[3]), .ext_irq_four_pin(pins[4]),
      .power_down, .wake_up, .timer_zero_toggle(tgl[0]), .timer_one_toggle(tgl[1]),
      .timer_two_toggle(tgl[2]), .timer_zero_clock_out(co[0]), .timer_one_clock_out(co[1]),
      .timer_two_clock_out(co[2]), .timer_zero_clock_out_en(coe[0]), .timer_one_clock_out_en(coe[1]),
      .timer_two_clock_out_en(coe[2]), .rc_osc_clk(rc), .ext_clk_in(ec), .xtal_osc_clk(xc),
      .master_clock_out_pin(mclk), .reset_pin, .device_reset, .reset_indicator_out, .irq);
   pin_ctrl_partner pin_ctrl_partner_inst (.sys_clk, .pin_cmd, .irq_pins(pins), .rc_osc_clk(rc),
      .ext_clk_in(ec), .xtal_osc_clk(xc));

   initial forever #25 sys_clk = ~sys_clk;

   // ==========================================================
   // compare, bus and closing tasks
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic near(string what, int exp, int got);
      total_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         error_cnt++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
      int t;
      t = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge sys_clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 50);
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      if (t >= 50) chk("bus answer", 0, 1);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         complete_run();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      int s, i, m, d, k, a, e, pend, en;
      logic src, ps, pm;
      s = $urandom(7536);
      repeat (6) @(posedge sys_clk);
      reset_n <= 1;
      foreach (offs[j]) begin
         bus(0, offs[j], 0);
         chk("reset value", 0, rd);
      end
      bus(1, 5'h18, 32'hffff_ffff);
      bus(0, 5'h18, 0);
      chk("unmapped read", 0, rd);
      bus(1, 5'h08, 32'h0000_001f);
      bus(0, 5'h08, 0);
      chk("status read only", 0, rd);
      chk("indicator after reset", 0, reset_indicator_out);
      for (i = 0; i < 8; i++) begin
         tgl <= 3'($urandom);
         bus(1, 5'h04, $urandom & 32'hfff8 | i);
         bus(0, 5'h04, 0);
         chk("clock out enables", i, coe);
         chk("clock out pins", i & tgl, co);
      end
      pend = 0;
      for (m = 0; m < 2; m++) begin
         s = ($urandom & 8'hfa) | (m ? 5 : 0);
         bus(1, 5'h00, s);
         bus(0, 5'h00, 0);
         chk("timer control", s, rd);
         for (i = 0; i < 5; i++) begin
            en = $urandom & 5'h1f;
            bus(1, 5'h10, en);
            for (k = 0; k < 2; k++) begin
               pin_cmd[i] <= k;
               repeat (6) @(posedge sys_clk);
               if (k == 0 || (i < 2 && m == 0)) pend = 1 << i;
               bus(0, 5'h08, 0);
               chk("pending flags", pend, rd);
               chk("irq level", (pend & en) != 0, irq);
               bus(1, 5'h0c, 32'h1f);
               pend = 0;
            end
         end
      end
      for (i = 0; i < 5; i++) begin
         power_down <= 1;
         repeat (2) @(posedge sys_clk);
         pin_cmd[i] <= 0;
         repeat (4) @(posedge sys_clk);
         chk("wake", i != 0, wake_up);
         power_down <= 0;
         pin_cmd[i] <= 1;
         repeat (3) @(posedge sys_clk);
         chk("wake released", 0, wake_up);
      end
      for (s = 0; s < 4; s++) begin
         for (d = 0; d < 4; d++) begin
            bus(1, 5'h14, 3 | d << 2 | s << 4);
            repeat (20) @(posedge sys_clk);
            chk("indicator raised", 1, reset_indicator_out);
            a = 0;
            e = 0;
            ps = s == 1 ? ec : s == 2 ? xc : rc;
            pm = mclk;
            for (k = 0; k < 360; k++) begin
               @(posedge sys_clk);
               src = s == 1 ? ec : s == 2 ? xc : rc;
               a += src && !ps;
               e += mclk && !pm;
               ps = src;
               pm = mclk;
            end
            near("master clock rises", d == 3 ? 0 : a >> d, e);
            if (d == 3) chk("master clock off", 0, mclk);
         end
      end
      reset_pin <= 1;
      @(posedge sys_clk);
      reset_pin <= 0;
      repeat (8) @(posedge sys_clk);
      chk("short reset pulse", 0, device_reset);
      reset_pin <= 1;
      repeat (9) @(posedge sys_clk);
      chk("long reset pulse", 1, device_reset);
      chk("indicator in reset", 0, reset_indicator_out);
      reset_pin <= 0;
      repeat (8) @(posedge sys_clk);
      chk("reset released", 0, device_reset);
      complete_run();
   end
endmodule
